// >>> core/lcdc_cmd_decoder.sv
// command decoder of a dot-matrix lcd driver behind its parallel host port
//
// Overview of operation
// - command bytes AC/AD turn the static indicator off or on by D0.
// - after indicator on, the next command byte is its register value.
// - indicator value byte loads blink field from D1..D0, rest ignored.
// - drive byte 1101xxxx: D3 low frame inversion, D3 high line inversion.
// - after line inversion, the next command byte is the line number.
// - line number byte D4..D0 gives n+1 inverted lines, upper bits ignored.
// - all-on command while display off enters power save.
// - power save is standby with indicator on, otherwise sleep.
// - power save keeps modes and still serves display ram access.
// - all-on off command leaves power save.
// - sleep stops oscillator, supply, drivers; segment and common grounded.
// - standby stops supply and dynamic drive, keeps oscillator, indicator.
// - reset command during standby moves the device into sleep.
// - byte E3 is a no-operation and changes no state except leaving test.
// - 1111xxxx enters test only with test pin high; no-operation exits.
// - start line loads upper 3 bits by 011 prefix, lower 4 by 010.
// - 1011xxxx loads the display ram page address.
// - column loads upper nibble by 0001 prefix, lower nibble by 0000.
// - command read returns status on D7..D4 and zeros on D3..D0.
// - data write stores the byte into display ram at current address.
// - A4/A5 choose normal or all-on display.
// - reset command reinitialises addresses, scan, modes; ram untouched.
`timescale 1ns/1ns
module lcdc_cmd_decoder
(
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RESETN_IN,
  // host parallel port
  input  wire logic [7:0] D_IN,
  output logic      [7:0] D_OUT,
  output logic            D_OE_OUT,
  input  wire logic       CMD_DATA_SELECT_IN,
  input  wire logic       RD_N_IN,
  input  wire logic       WR_N_IN,
  input  wire logic       FACTORY_TEST_PIN_IN,
  // display ram side
  output logic            RAM_WE_OUT,
  output logic      [3:0] RAM_PAGE_OUT,
  output logic      [7:0] RAM_COL_OUT,
  output logic      [7:0] RAM_WDATA_OUT,
  input  wire logic [7:0] RAM_RDATA_IN,
  // display settings
  output logic            DISP_ON_OUT,
  output logic            ALL_ON_OUT,
  output logic      [6:0] START_LINE_OUT,
  output logic      [3:0] PAGE_OUT,
  output logic      [7:0] COLUMN_OUT,
  output logic            COM_REV_OUT,
  output logic            RMW_OUT,
  output logic            LINE_INV_OUT,
  output logic      [4:0] LINE_CNT_OUT,
  output logic            SI_ON_OUT,
  output logic      [1:0] SI_BLINK_OUT,
  output logic            TEST_MODE_OUT,
  // power state controls
  output logic            SLEEP_OUT,
  output logic            STANDBY_OUT,
  output logic            OSC_EN_OUT,
  output logic            SUPPLY_EN_OUT,
  output logic            DYN_DRIVE_EN_OUT,
  output logic            STATIC_DRIVE_EN_OUT,
  output logic            SEG_COM_GND_OUT
);

  lcdc_pkg::lcdc_state_s r;
  lcdc_pkg::lcdc_state_s n;
  logic       wr_end;
  logic       rd_start;
  logic       wr_cmd;
  logic       wr_dat;
  logic       cmd_free;
  logic [7:0] b;
  logic [3:0] status;

  // command match under mask, used all over the decoder
  function automatic logic cmd_is(input logic [7:0] v,
                                  input logic [7:0] c,
                                  input logic [7:0] m);
    return (v & m) == c;
  endfunction

  // strobe edges are taken from the second sync stage only
  assign wr_end   = ~r.wr_d & r.c_s2[0];
  assign rd_start = r.rd_d & ~r.c_s2[1];
  assign wr_cmd   = wr_end & ~r.c_s2[2];
  assign wr_dat   = wr_end & r.c_s2[2];
  assign b        = r.d_s2;
  // a plain command acts only with no value byte pending and no test
  assign cmd_free = wr_cmd & ~r.pend_si & ~r.pend_li & ~r.test;
  // status nibble: busy, read-modify-write, display off, test
  assign status   = {1'b0, r.rmw, ~r.disp_on, r.test};

  // next state
  always_comb
  begin
    n        = r;
    n.d_s1   = D_IN;
    n.d_s2   = r.d_s1;
    n.c_s1   = {CMD_DATA_SELECT_IN, RD_N_IN, WR_N_IN};
    n.c_s2   = r.c_s1;
    n.t_s1   = FACTORY_TEST_PIN_IN;
    n.t_s2   = r.t_s1;
    n.wr_d   = r.c_s2[0];
    n.rd_d   = r.c_s2[1];
    n.ram_we = 1'b0;
    // value bytes of two-byte commands take any code
    if (wr_cmd && r.pend_si)
    begin
      n.blink   = b[1:0];
      n.pend_si = 1'b0;
    end
    else if (wr_cmd && r.pend_li)
    begin
      n.line_cnt = b[4:0];
      n.pend_li  = 1'b0;
    end
    else if (wr_cmd && r.test)
    begin
      // only a no-operation leaves test
      if (cmd_is(b, lcdc_pkg::LCDC_CMD_NOP, lcdc_pkg::LCDC_MASK_FULL))
        n.test = 1'b0;
    end
    else if (cmd_free)
    begin
      if (cmd_is(b, lcdc_pkg::LCDC_CMD_SI_OFF, lcdc_pkg::LCDC_MASK_BIT0))
      begin
        n.si_on   = b[0];
        n.pend_si = b[0];
      end
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_DISP, lcdc_pkg::LCDC_MASK_BIT0))
        n.disp_on = b[0];
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_ALLON, lcdc_pkg::LCDC_MASK_BIT0))
      begin
        n.all_on = b[0];
        if (!b[0])
          n.ps = lcdc_pkg::LCDC_PS_RUN;
        else if (!r.disp_on && r.ps == lcdc_pkg::LCDC_PS_RUN)
          n.ps = r.si_on ? lcdc_pkg::LCDC_PS_STBY
                         : lcdc_pkg::LCDC_PS_SLEEP;
      end
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_DRIVE, lcdc_pkg::LCDC_MASK_DRV))
      begin
        n.line_inv = b[lcdc_pkg::LCDC_DRV_LINE_BIT];
        n.pend_li  = b[lcdc_pkg::LCDC_DRV_LINE_BIT];
      end
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_TEST, lcdc_pkg::LCDC_MASK_NIB))
        n.test = r.t_s2;
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_RESET, lcdc_pkg::LCDC_MASK_FULL))
      begin
        // ram contents and display on/off are left alone
        n.start_line = '0;
        n.column     = '0;
        n.page       = '0;
        n.com_rev    = 1'b0;
        n.rmw        = 1'b0;
        n.si_on      = 1'b0;
        n.blink      = lcdc_pkg::LCDC_BLINK_RST;
        if (r.ps == lcdc_pkg::LCDC_PS_STBY)
          n.ps = lcdc_pkg::LCDC_PS_SLEEP;
      end
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_RMW, lcdc_pkg::LCDC_MASK_FULL))
      begin
        n.rmw     = 1'b1;
        n.rmw_col = r.column;
      end
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_END, lcdc_pkg::LCDC_MASK_FULL))
      begin
        n.rmw = 1'b0;
        if (r.rmw)
          n.column = r.rmw_col;
      end
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_COMDIR,
                      lcdc_pkg::LCDC_MASK_COMDIR))
        n.com_rev = b[lcdc_pkg::LCDC_COMDIR_BIT];
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_PAGE, lcdc_pkg::LCDC_MASK_NIB))
        n.page = b[3:0];
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_COL_HI, lcdc_pkg::LCDC_MASK_NIB))
        n.column[7:4] = b[3:0];
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_COL_LO, lcdc_pkg::LCDC_MASK_NIB))
        n.column[3:0] = b[3:0];
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_SL_HI, lcdc_pkg::LCDC_MASK_TOP3))
        n.start_line[6:4] = b[2:0];
      else if (cmd_is(b, lcdc_pkg::LCDC_CMD_SL_LO, lcdc_pkg::LCDC_MASK_TOP3))
        n.start_line[3:0] = b[3:0];
      // e3 and unknown codes fall through untouched
    end
    // ram access is served in every power state and while a value pends
    if (wr_dat)
    begin
      n.ram_we    = 1'b1;
      n.ram_page  = r.page;
      n.ram_col   = r.column;
      n.ram_wdata = b;
      n.column    = r.column + lcdc_pkg::LCDC_COL_STEP;
    end
    // read data is caught once at the falling read strobe
    if (rd_start)
    begin
      if (r.c_s2[2])
      begin
        n.rd_data = RAM_RDATA_IN;
        if (!r.rmw)
          n.column = r.column + lcdc_pkg::LCDC_COL_STEP;
      end
      else
        n.rd_data = {status, 4'h0};
    end
  end

  // state register
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      r          <= '0;
      r.c_s1     <= lcdc_pkg::LCDC_CTL_IDLE;
      r.c_s2     <= lcdc_pkg::LCDC_CTL_IDLE;
      r.wr_d     <= 1'b1;
      r.rd_d     <= 1'b1;
      r.ps       <= lcdc_pkg::LCDC_PS_RUN;
      r.line_cnt <= lcdc_pkg::LCDC_LINE_CNT_RST;
    end
    else
      r <= n;
  end

  // host port and settings straight from the state
  assign D_OUT          = r.rd_data;
  assign D_OE_OUT       = ~r.rd_d;
  assign RAM_WE_OUT     = r.ram_we;
  assign RAM_PAGE_OUT   = r.ram_page;
  assign RAM_COL_OUT    = r.ram_col;
  assign RAM_WDATA_OUT  = r.ram_wdata;
  assign DISP_ON_OUT    = r.disp_on;
  assign ALL_ON_OUT     = r.all_on;
  assign START_LINE_OUT = r.start_line;
  assign PAGE_OUT       = r.page;
  assign COLUMN_OUT     = r.column;
  assign COM_REV_OUT    = r.com_rev;
  assign RMW_OUT        = r.rmw;
  assign LINE_INV_OUT   = r.line_inv;
  assign LINE_CNT_OUT   = r.line_cnt;
  assign SI_ON_OUT      = r.si_on;
  assign SI_BLINK_OUT   = r.blink;
  assign TEST_MODE_OUT  = r.test;

  // power controls: sleep stops all, standby keeps clock and indicator
  assign SLEEP_OUT           = r.ps == lcdc_pkg::LCDC_PS_SLEEP;
  assign STANDBY_OUT         = r.ps == lcdc_pkg::LCDC_PS_STBY;
  assign OSC_EN_OUT          = ~SLEEP_OUT;
  assign SUPPLY_EN_OUT       = r.ps == lcdc_pkg::LCDC_PS_RUN;
  assign DYN_DRIVE_EN_OUT    = SUPPLY_EN_OUT;
  assign SEG_COM_GND_OUT     = ~SUPPLY_EN_OUT;
  assign STATIC_DRIVE_EN_OUT = STANDBY_OUT | (SUPPLY_EN_OUT & r.si_on);

  // checks beside the logic
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  sequence s_free(logic [7:0] c);
    cmd_free && b == c;
  endsequence

  sequence s_value;
    wr_cmd && (r.pend_si || r.pend_li);
  endsequence

  a_si_pending: assert property (
    s_free(lcdc_pkg::LCDC_CMD_SI_ON) |=> r.pend_si && SI_ON_OUT)
    else $error("indicator on did not arm value byte");
  a_blink_load: assert property (
    s_value and r.pend_si |=> !r.pend_si && SI_BLINK_OUT == $past(b[1:0]))
    else $error("blink field not loaded");
  a_line_count: assert property (
    s_value and !r.pend_si |=> !r.pend_li
      && LINE_CNT_OUT == $past(b[4:0]))
    else $error("line count not loaded");
  a_drive_frame: assert property (
    cmd_free && b[7:4] == 4'hD && !b[3] |=> !LINE_INV_OUT && !r.pend_li)
    else $error("frame inversion not selected");
  a_ps_standby: assert property (
    s_free(8'hA5) and (!r.disp_on && r.si_on && SUPPLY_EN_OUT)
      |=> STANDBY_OUT && OSC_EN_OUT && SEG_COM_GND_OUT)
    else $error("standby not entered");
  a_ps_sleep: assert property (
    s_free(8'hA5) and (!r.disp_on && !r.si_on && SUPPLY_EN_OUT)
      |=> SLEEP_OUT && !OSC_EN_OUT && !STATIC_DRIVE_EN_OUT)
    else $error("sleep not entered");
  a_ps_leave: assert property (
    s_free(lcdc_pkg::LCDC_CMD_ALLON) |=> SUPPLY_EN_OUT && !ALL_ON_OUT)
    else $error("power save not left");
  a_stby_reset: assert property (
    s_free(lcdc_pkg::LCDC_CMD_RESET) and STANDBY_OUT
      |=> SLEEP_OUT && START_LINE_OUT == 7'h00)
    else $error("reset in standby did not sleep");
  a_nop_quiet: assert property (
    s_free(lcdc_pkg::LCDC_CMD_NOP) and (!rd_start && !wr_dat)
      |=> $stable(r.column) && $stable(r.ps) && $stable(r.page))
    else $error("no-operation changed state");
  a_test_gate: assert property (
    cmd_free && b[7:4] == 4'hF && !r.t_s2 |=> !TEST_MODE_OUT)
    else $error("test entered with pin low");
  a_status_read: assert property (
    rd_start && !r.c_s2[2] |=> D_OE_OUT && D_OUT[3:0] == 4'h0
      && D_OUT[7:4] == $past(status))
    else $error("status byte wrong");
  a_data_write: assert property (
    wr_dat |=> RAM_WE_OUT && RAM_WDATA_OUT == $past(b)
      && RAM_COL_OUT == $past(r.column) ##1 !RAM_WE_OUT)
    else $error("ram write wrong");

endmodule

// >>> core/lcdc_pkg.sv
// constants, state encodings and state record of the lcd command decoder
package lcdc_pkg;

  // command bytes and match masks
  localparam logic [7:0] LCDC_CMD_SI_OFF   = 8'hAC;
  localparam logic [7:0] LCDC_CMD_SI_ON    = 8'hAD;
  localparam logic [7:0] LCDC_CMD_DISP     = 8'hAE;
  localparam logic [7:0] LCDC_CMD_ALLON    = 8'hA4;
  localparam logic [7:0] LCDC_CMD_NOP      = 8'hE3;
  localparam logic [7:0] LCDC_CMD_RESET    = 8'hE2;
  localparam logic [7:0] LCDC_CMD_RMW      = 8'hE0;
  localparam logic [7:0] LCDC_CMD_END      = 8'hEE;
  localparam logic [7:0] LCDC_CMD_DRIVE    = 8'hD0;
  localparam logic [7:0] LCDC_CMD_TEST     = 8'hF0;
  localparam logic [7:0] LCDC_CMD_COMDIR   = 8'hC0;
  localparam logic [7:0] LCDC_CMD_PAGE     = 8'hB0;
  localparam logic [7:0] LCDC_CMD_COL_HI   = 8'h10;
  localparam logic [7:0] LCDC_CMD_COL_LO   = 8'h00;
  localparam logic [7:0] LCDC_CMD_SL_HI    = 8'h60;
  localparam logic [7:0] LCDC_CMD_SL_LO    = 8'h40;
  localparam logic [7:0] LCDC_MASK_FULL    = 8'hFF;
  localparam logic [7:0] LCDC_MASK_BIT0    = 8'hFE;
  localparam logic [7:0] LCDC_MASK_NIB     = 8'hF0;
  localparam logic [7:0] LCDC_MASK_DRV     = 8'hF0;
  localparam logic [7:0] LCDC_MASK_COMDIR  = 8'hF0;
  localparam logic [7:0] LCDC_MASK_TOP3    = 8'hE0;

  // field positions
  localparam int LCDC_DRV_LINE_BIT = 3;
  localparam int LCDC_COMDIR_BIT   = 3;

  // values after reset and column address step
  localparam logic [2:0] LCDC_CTL_IDLE     = 3'h3;
  localparam logic [4:0] LCDC_LINE_CNT_RST = 5'h00;
  localparam logic [1:0] LCDC_BLINK_RST    = 2'h0;
  localparam logic [7:0] LCDC_COL_STEP     = 8'h01;

  // power state, one-hot
  typedef enum logic [2:0]
  {
    LCDC_PS_RUN   = 3'b001,
    LCDC_PS_SLEEP = 3'b010,
    LCDC_PS_STBY  = 3'b100
  } lcdc_ps_e;

  // whole state of the decoder
  typedef struct packed
  {
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [2:0] c_s1;
    logic [2:0] c_s2;
    logic       t_s1;
    logic       t_s2;
    logic       wr_d;
    logic       rd_d;
    lcdc_ps_e   ps;
    logic       disp_on;
    logic       all_on;
    logic       si_on;
    logic [1:0] blink;
    logic       pend_si;
    logic       pend_li;
    logic       line_inv;
    logic [4:0] line_cnt;
    logic [6:0] start_line;
    logic [3:0] page;
    logic [7:0] column;
    logic [7:0] rmw_col;
    logic       rmw;
    logic       com_rev;
    logic       test;
    logic       ram_we;
    logic [3:0] ram_page;
    logic [7:0] ram_col;
    logic [7:0] ram_wdata;
    logic [7:0] rd_data;
  } lcdc_state_s;

endpackage

// >>> dv/lcd_command_decoder_ctrl_test.sv
// self-checking bench of the lcd command decoder
`timescale 1ns/1ns
module lcd_command_decoder_ctrl_test;
  logic        clk;
  logic        resetn;
  logic        test_pin;
  logic [7:0]  ram_rdata;
  logic [7:0]  d_host;
  logic        sel, rd_n, wr_n;
  wire  [7:0]  d_dev, ram_col, ram_wd, column;
  wire  [3:0]  ram_page, page;
  wire  [6:0]  start_line;
  wire  [4:0]  line_cnt;
  wire  [1:0]  si_blink;
  wire         d_oe, ram_we, disp_on, all_on, line_inv, si_on, test_mode;
  wire         com_rev, rmw;
  wire         sleep, standby, osc_en, supply_en, dyn_en, stat_en, gnd;
  wire  [7:0]  pwr;
  int          n_tests;
  int          n_mismatch;
  int          n_we;
  logic [19:0] cap;

  // power outputs as one vector: sleep,standby,osc,supply,dyn,static,gnd
  assign pwr = {1'b0, sleep, standby, osc_en, supply_en, dyn_en, stat_en, gnd};

  always #4 clk = ~clk;

  lcdc_cmd_decoder u_dut
  (
    .CLK_IN (clk), .RESETN_IN (resetn), .D_IN (d_host), .D_OUT (d_dev),
    .D_OE_OUT (d_oe), .CMD_DATA_SELECT_IN (sel), .RD_N_IN (rd_n),
    .WR_N_IN (wr_n), .FACTORY_TEST_PIN_IN (test_pin),
    .RAM_WE_OUT (ram_we), .RAM_PAGE_OUT (ram_page), .RAM_COL_OUT (ram_col),
    .RAM_WDATA_OUT (ram_wd), .RAM_RDATA_IN (ram_rdata),
    .DISP_ON_OUT (disp_on), .ALL_ON_OUT (all_on),
    .START_LINE_OUT (start_line), .PAGE_OUT (page), .COLUMN_OUT (column),
    .COM_REV_OUT (com_rev), .RMW_OUT (rmw), .LINE_INV_OUT (line_inv),
    .LINE_CNT_OUT (line_cnt), .SI_ON_OUT (si_on), .SI_BLINK_OUT (si_blink),
    .TEST_MODE_OUT (test_mode), .SLEEP_OUT (sleep), .STANDBY_OUT (standby),
    .OSC_EN_OUT (osc_en), .SUPPLY_EN_OUT (supply_en),
    .DYN_DRIVE_EN_OUT (dyn_en), .STATIC_DRIVE_EN_OUT (stat_en),
    .SEG_COM_GND_OUT (gnd)
  );

  lcdc_host_model u_host
  (
    .clk_in (clk), .d_in (d_dev), .d_oe_in (d_oe), .d_out (d_host),
    .sel_out (sel), .rd_n_out (rd_n), .wr_n_out (wr_n)
  );

  // record every ram write pulse so its count proves a single cycle
  always @(posedge clk)
  begin
    if (ram_we === 1'b1)
    begin
      n_we <= n_we + 1;
      cap  <= {ram_page, ram_col, ram_wd};
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    u_host.write_byte(1'b0, b);
  endtask

  task automatic status(input logic [7:0] exp);
    logic [7:0] v;
    logic       oe;
    u_host.read_byte(1'b0, v, oe);
    chk(v, exp);
    chk({7'h00, oe}, 8'h01);
  endtask

  task automatic t_indicator;
    cmd(8'hAD);
    cmd(8'hAF); // value byte, not display on
    chk({7'h00, si_on}, 8'h01);
    chk({6'h00, si_blink}, 8'h03);
    chk({7'h00, disp_on}, 8'h00);
    cmd(8'hAD);
    cmd(8'hFE);
    chk({6'h00, si_blink}, 8'h02);
    cmd(8'hAD);
    cmd(8'hE1); // nop-like byte still taken as value
    chk({6'h00, si_blink}, 8'h01);
    cmd(8'hAC);
    chk({7'h00, si_on}, 8'h00);
    $display("test indicator finished");
  endtask

  task automatic t_drive;
    // line inversion pairs sent back to back as the host must
    cmd(8'hD8);
    chk({7'h00, line_inv}, 8'h01);
    cmd(8'hAF);
    chk({3'h0, line_cnt}, 8'h0F);
    chk({7'h00, disp_on}, 8'h00);
    cmd(8'hD7);
    chk({7'h00, line_inv}, 8'h00);
    cmd(8'hDF);
    cmd(8'hFF);
    chk({3'h0, line_cnt}, 8'h1F);
    $display("test drive finished");
  endtask

  task automatic t_test;
    cmd(8'hE3);
    chk({3'h0, line_cnt}, 8'h1F);
    chk({6'h00, line_inv, test_mode}, 8'h02);
    cmd(8'hF0);
    chk({7'h00, test_mode}, 8'h00);
    @(posedge clk);
    test_pin <= 1'b1;
    cmd(8'hF5);
    chk({7'h00, test_mode}, 8'h01);
    status(8'h30);
    cmd(8'hAF); // ignored while testing
    chk({7'h00, disp_on}, 8'h00);
    cmd(8'hE3);
    chk({7'h00, test_mode}, 8'h00);
    $display("test factory finished");
  endtask

  task automatic t_display;
    cmd(8'hAF);
    chk({7'h00, disp_on}, 8'h01);
    status(8'h00);
    cmd(8'hA5);
    chk({7'h00, all_on}, 8'h01);
    chk(pwr, 8'h1C);
    cmd(8'hA4);
    chk({7'h00, all_on}, 8'h00);
    cmd(8'hAE);
    chk({7'h00, disp_on}, 8'h00);
    status(8'h20);
    $display("test display finished");
  endtask

  task automatic t_power;
    cmd(8'hA5);
    chk(pwr, 8'h41);
    u_host.write_byte(1'b1, 8'h5A);
    chk(n_we[7:0], 8'h01);
    chk({7'h00, line_inv}, 8'h01);
    cmd(8'hA4);
    chk(pwr, 8'h1C);
    cmd(8'hAD);
    cmd(8'h03);
    cmd(8'hA5);
    chk(pwr, 8'h33);
    cmd(8'hE2);
    chk(pwr, 8'h41);
    cmd(8'hA4);
    chk(pwr, 8'h1C);
    $display("test power finished");
  endtask

  task automatic t_addr;
    logic [7:0] v;
    logic       oe;
    cmd(8'h65);
    cmd(8'h4A);
    chk({1'b0, start_line}, 8'h5A);
    cmd(8'hB7);
    chk({4'h0, page}, 8'h07);
    cmd(8'h13);
    cmd(8'h0C);
    chk(column, 8'h3C);
    u_host.write_byte(1'b1, 8'h96);
    chk(n_we[7:0], 8'h02);
    chk({4'h0, cap[19:16]}, 8'h07);
    chk(cap[15:8], 8'h3C);
    chk(cap[7:0], 8'h96);
    chk(column, 8'h3D);
    @(posedge clk);
    ram_rdata <= 8'hC3;
    u_host.read_byte(1'b1, v, oe);
    chk(v, 8'hC3);
    chk(column, 8'h3E);
    // scan direction and read-modify-write set so reset has work to do
    cmd(8'hC8);
    cmd(8'hE0);
    chk({6'h00, com_rev, rmw}, 8'h03);
    status(8'h60);
    u_host.read_byte(1'b1, v, oe);
    chk(column, 8'h3E);
    cmd(8'hE2);
    chk({6'h00, com_rev, rmw}, 8'h00);
    chk({1'b0, start_line}, 8'h00);
    chk({page, 4'h0}, 8'h00);
    chk(column, 8'h00);
    $display("test address finished");
  endtask

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    test_pin = 1'b0;
    ram_rdata = 8'h00;
    n_tests = 0;
    n_mismatch = 0;
    n_we = 0;
    cap = 20'h00000;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(pwr, 8'h1C);
    chk({6'h00, d_oe, disp_on}, 8'h00);
    $display("test reset finished");
    t_indicator;
    t_drive;
    t_test;
    t_display;
    t_power;
    t_addr;
    finish_test;
  end

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end

endmodule

// >>> dv/lcdc_host_model.sv
// host microcontroller model on the parallel port of the decoder
`timescale 1ns/1ns
module lcdc_host_model
(
  // clock
  input  wire logic       clk_in,
  // bus seen from the device
  input  wire logic [7:0] d_in,
  input  wire logic       d_oe_in,
  // bus driven by the host
  output logic      [7:0] d_out,
  output logic            sel_out,
  output logic            rd_n_out,
  output logic            wr_n_out
);

  // strobes idle high before reset release
  initial
  begin
    d_out    = 8'h00;
    sel_out  = 1'b0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
  end

  // one write strobe; byte held until the device has synchronised it
  task automatic write_byte(input logic sel, input logic [7:0] b);
    @(posedge clk_in);
    sel_out  <= sel;
    d_out    <= b;
    wr_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    // released bus shows the inverse, never a stale copy
    d_out <= ~b;
    repeat (2) @(posedge clk_in);
  endtask

  // one read strobe, long enough for the synchronised answer
  task automatic read_byte(input logic sel, output logic [7:0] v,
                           output logic oe);
    @(posedge clk_in);
    sel_out  <= sel;
    rd_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    v = d_in;
    oe = d_oe_in;
    rd_n_out <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask

endmodule
